// File: dmr_controller.sv
// dmr_controller: memory controller end, ordered by software over an avalon-mm slave.
// assumes sys_clk is shared with the device; one command in flight on the bus per cycle.
`timescale 1ns/1ps
`default_nettype none
module dmr_controller import dmr_pkg::*; #(
	parameter int CAS_READ = CAS_READ_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	dmr_if.ctl mem
);
	logic ack;
	logic take;
	logic busy;
	logic issue;
	logic refuse;
	dmr_cmd_e kind;
	logic [BA_W-1:0] cmd_ba;
	logic [ADDR_W-1:0] cmd_a;
	logic [ADDR_W-1:0] masked_a;
	logic [DQ_W-1:0] wdata;
	logic [DQ_W-1:0] rdata;
	logic rvalid;
	logic refused;
	logic pattern_on;
	logic [1:0] al_code;
	logic [2:0] cwl_code;
	logic [7:0] open_banks;
	logic [3:0] pre_cnt;
	logic [PIPE_W-1:0] wr_pipe;
	logic [PIPE_W-1:0] next_wr_pipe;
	logic [31:0] next_readdata;
	int wr_lat;

	assign busy = |wr_pipe;
	// a command write waits while write data is still pending
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign take = (avs_read || avs_write) && ack;
	assign kind = dmr_cmd_e'(avs_writedata[2:0]);
	assign cmd_ba = avs_writedata[CMD_BA_LSB +: BA_W];
	assign cmd_a = avs_writedata[CMD_ADDR_LSB +: ADDR_W];
	assign issue = take && avs_write && avs_address == REG_CMD;
	assign wr_lat = al_cycles(al_code, CAS_READ) + cwl_cycles(cwl_code);

	always_comb begin
		masked_a = cmd_a;
		if (cmd_ba[1:0] == BA_MR2[1:0]) begin
			masked_a = cmd_a & ~MR2_RSVD_MASK;
		end else if (cmd_ba[1:0] == BA_MR3[1:0]) begin
			masked_a = cmd_a & MR3_KEEP_MASK;
		end
	end

	always_comb begin
		refuse = 1'b0;
		if (pattern_on && kind != DMR_CMD_RD && kind != DMR_CMD_RST) begin
			refuse = !(kind == DMR_CMD_MRS && cmd_ba[1:0] == BA_MR3[1:0]
				&& !masked_a[PAT_EN_BIT]);
		end
		if (kind == DMR_CMD_MRS && cmd_ba[1:0] == BA_MR3[1:0] && masked_a[PAT_EN_BIT]
			&& (open_banks != 8'h00 || pre_cnt != 4'h0)) begin
			refuse = 1'b1;
		end
	end

	always_comb begin
		case (avs_address)
			REG_WDATA: next_readdata = {16'h0000, wdata};
			REG_RDATA: next_readdata = {16'h0000, rdata};
			REG_STATUS: next_readdata = {28'h0000000, pattern_on, refused, rvalid, busy};
			default: next_readdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ack <= (avs_read || avs_write) && !ack
				&& !(avs_write && avs_address == REG_CMD && busy);
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wdata <= '0;
		end else if (take && avs_write && avs_address == REG_WDATA) begin
			wdata <= avs_writedata[DQ_W-1:0];
		end
	end

	// a new word arriving in the clearing cycle keeps the valid flag
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata <= '0;
			rvalid <= 1'b0;
		end else if (!mem.dev_dq_oe_n) begin
			rdata <= mem.dq;
			rvalid <= 1'b1;
		end else if (take && avs_read && avs_address == REG_RDATA) begin
			rvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refused <= 1'b0;
		end else if (issue && refuse) begin
			refused <= 1'b1;
		end else if (take && avs_write && avs_address == REG_STATUS
			&& avs_writedata[ST_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mem.cs_n <= 1'b1;
			{mem.ras_n, mem.cas_n, mem.we_n} <= PINS_NOP;
			mem.ba <= '0;
			mem.addr <= '0;
			mem.rst_n <= 1'b1;
		end else begin
			mem.cs_n <= !(issue && !refuse && kind != DMR_CMD_NOP && kind != DMR_CMD_RST);
			{mem.ras_n, mem.cas_n, mem.we_n} <= (issue && !refuse) ? cmd_pins(kind) : PINS_NOP;
			// mode-set always drives bank bit 2 low
			mem.ba <= (kind == DMR_CMD_MRS) ? {1'b0, cmd_ba[1:0]} : cmd_ba;
			mem.addr <= (kind == DMR_CMD_MRS) ? masked_a : cmd_a;
			mem.rst_n <= !(issue && kind == DMR_CMD_RST);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || (issue && kind == DMR_CMD_RST)) begin
			al_code <= '0;
			cwl_code <= '0;
			pattern_on <= 1'b0;
			open_banks <= '0;
			pre_cnt <= '0;
		end else begin
			pre_cnt <= (pre_cnt != 4'h0) ? pre_cnt - 4'h1 : 4'h0;
			if (issue && !refuse) begin
				case (kind)
					DMR_CMD_MRS: begin
						if (cmd_ba[1:0] == BA_MR1[1:0]) begin
							al_code <= masked_a[AL_LSB +: 2];
						end
						if (cmd_ba[1:0] == BA_MR2[1:0]) begin
							cwl_code <= masked_a[CWL_LSB +: 3];
						end
						if (cmd_ba[1:0] == BA_MR3[1:0]) begin
							pattern_on <= masked_a[PAT_EN_BIT];
						end
					end
					DMR_CMD_ACT: open_banks[cmd_ba] <= 1'b1;
					DMR_CMD_PRE: begin
						if (cmd_a[AP_BIT]) begin
							open_banks <= '0;
						end else begin
							open_banks[cmd_ba] <= 1'b0;
						end
						pre_cnt <= 4'(PRECHARGE_CYC);
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_comb begin
		next_wr_pipe = wr_pipe >> 1;
		if (issue && !refuse && kind == DMR_CMD_WR) begin
			next_wr_pipe[wr_lat - 1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_pipe <= '0;
			mem.ctl_dq <= '0;
			mem.ctl_dq_oe_n <= 1'b1;
			mem.odt <= 1'b0;
		end else begin
			wr_pipe <= next_wr_pipe;
			mem.ctl_dq <= wdata;
			mem.ctl_dq_oe_n <= !wr_pipe[0];
			mem.odt <= |next_wr_pipe;
		end
	end
endmodule
`default_nettype wire

// File: dmr_device.sv
// dmr_device: memory-side decode of the mode registers, pattern readout and latencies.
// assumes commands are synchronous to sys_clk; one data word per read or write burst.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - output-disable bit tristates all data outputs
// - bank 2 mode-set loads write-side register
// - controller zeroes write-side reserved bits
// - write cas delay code gives 5 to 8
// - whole-cycle latencies only, no half cycles
// - write data at additive plus write delay
// - rtt_wr code: off, quarter, half, reserved
// - write termination applies without nominal termination
// - write leveling forces nominal termination only
// - bank 3 mode-set loads pattern register
// - controller zeroes pattern register reserved bits
// - bit two enables pattern readout
// - location ignored while readout disabled
// - location zero is predefined pattern, others reserved
// - controller enables readout only with banks idle
// - reads served from pattern while enabled
// - controller issues only reads and the bank 3 mode-set that turns readout off during readout
// - memory reset works during pattern readout
// - read data at additive plus cas delay
module dmr_device import dmr_pkg::*; #(
	parameter int CAS_READ = CAS_READ_DEFAULT,
	parameter int MEM_DEPTH = MEM_DEPTH_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic reset,
	dmr_if.dev mem,
	output logic [5:0] total_write_delay,
	output logic [5:0] total_read_delay,
	output logic self_refresh_temp_range,
	output logic pattern_readout,
	output logic output_disabled,
	output dmr_term_e term_state,
	output logic mode_reserved
);
	localparam int IDX_W = $clog2(MEM_DEPTH);

	logic [ADDR_W-1:0] first_extended_mode_register;
	logic [ADDR_W-1:0] write_side_mode_register;
	logic [ADDR_W-1:0] pattern_readout_mode_register;
	logic [DQ_W-1:0] array_mem [MEM_DEPTH];
	logic [PIPE_W-1:0] rd_pipe;
	logic [PIPE_W-1:0] next_rd_pipe;
	logic [PIPE_W-1:0] wr_pipe;
	logic [PIPE_W-1:0] next_wr_pipe;
	logic [IDX_W-1:0] rd_col [PIPE_W];
	logic [IDX_W-1:0] wr_col [PIPE_W];
	logic [PIPE_W-1:0] rd_pat;
	logic [DQ_W-1:0] dev_dq;
	logic dev_dq_oe_n;
	logic [2:0] pins;
	logic is_mrs;
	logic is_rd;
	logic is_wr;
	logic mem_clear;
	logic [1:0] rtt_wr;
	logic [2:0] rtt_nom;
	logic wlev;
	logic [1:0] pat_loc;
	dmr_term_e next_term;
	int rd_lat;
	int wr_lat;

	assign pins = {mem.ras_n, mem.cas_n, mem.we_n};
	// mode-set needs bank bit 2 low as well as the register select
	assign is_mrs = !mem.cs_n && pins == PINS_MRS && !mem.ba[2];
	assign is_rd = !mem.cs_n && pins == PINS_RD;
	assign is_wr = !mem.cs_n && pins == PINS_WR;
	// the memory reset pin stays live in every mode, readout included
	assign mem_clear = reset || !mem.rst_n;

	assign wlev = first_extended_mode_register[WLEV_BIT];
	assign rtt_wr = write_side_mode_register[RTTWR_LSB +: 2];
	assign rtt_nom = {first_extended_mode_register[NOM_B2], first_extended_mode_register[NOM_B1],
		first_extended_mode_register[NOM_B0]};
	assign pattern_readout = pattern_readout_mode_register[PAT_EN_BIT];
	// location only counts while readout is on
	assign pat_loc = pattern_readout ? pattern_readout_mode_register[PAT_LOC_LSB +: 2]
		: LOC_PREDEF;
	assign output_disabled = first_extended_mode_register[QOFF_BIT];
	assign self_refresh_temp_range = write_side_mode_register[SRT_BIT];

	// integer cycle counts only, so half-cycle settings cannot exist
	assign rd_lat = al_cycles(first_extended_mode_register[AL_LSB +: 2], CAS_READ)
		+ CAS_READ;
	assign wr_lat = al_cycles(first_extended_mode_register[AL_LSB +: 2], CAS_READ)
		+ cwl_cycles(write_side_mode_register[CWL_LSB +: 3]);
	assign total_read_delay = 6'(rd_lat);
	assign total_write_delay = 6'(wr_lat);

	assign mem.dev_dq = dev_dq;
	assign mem.dev_dq_oe_n = dev_dq_oe_n;

	always_ff @(posedge sys_clk) begin
		if (mem_clear) begin
			first_extended_mode_register <= '0;
			write_side_mode_register <= '0;
			pattern_readout_mode_register <= '0;
		end else if (is_mrs) begin
			if (mem.ba[1:0] == BA_MR1[1:0]) begin
				first_extended_mode_register <= mem.addr;
			end
			if (mem.ba[1:0] == BA_MR2[1:0]) begin
				write_side_mode_register <= mem.addr;
			end
			if (mem.ba[1:0] == BA_MR3[1:0]) begin
				pattern_readout_mode_register <= mem.addr;
			end
		end
	end

	// reserved codes are accepted but flagged; cwl 1xx decodes as the base latency
	always_ff @(posedge sys_clk) begin
		if (mem_clear) begin
			mode_reserved <= 1'b0;
		end else if (write_side_mode_register[CWL_LSB + 2] || rtt_wr == RTTWR_RSVD) begin
			mode_reserved <= 1'b1;
		end else if (pattern_readout && pat_loc != LOC_PREDEF) begin
			mode_reserved <= 1'b1;
		end
	end

	// reads land one slot short so the output flop meets the latency exactly
	always_comb begin
		next_rd_pipe = rd_pipe >> 1;
		next_wr_pipe = wr_pipe >> 1;
		if (is_rd) begin
			next_rd_pipe[rd_lat - 2] = 1'b1;
		end
		// writes are dropped while the pattern is being read out
		if (is_wr && !pattern_readout) begin
			next_wr_pipe[wr_lat - 1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (mem_clear) begin
			rd_pipe <= '0;
			wr_pipe <= '0;
		end else begin
			rd_pipe <= next_rd_pipe;
			wr_pipe <= next_wr_pipe;
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < PIPE_W - 1; i++) begin
			rd_col[i] <= rd_col[i + 1];
			wr_col[i] <= wr_col[i + 1];
			rd_pat[i] <= rd_pat[i + 1];
		end
		rd_col[PIPE_W - 1] <= '0;
		wr_col[PIPE_W - 1] <= '0;
		rd_pat[PIPE_W - 1] <= 1'b0;
		if (is_rd) begin
			rd_col[rd_lat - 2] <= mem.addr[IDX_W-1:0];
			rd_pat[rd_lat - 2] <= pattern_readout;
		end
		if (is_wr) begin
			wr_col[wr_lat - 1] <= mem.addr[IDX_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wr_pipe[0]) begin
			array_mem[wr_col[0]] <= mem.dq;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (mem_clear) begin
			dev_dq <= '0;
		end else if (rd_pipe[0]) begin
			if (rd_pat[0]) begin
				dev_dq <= (pat_loc == LOC_PREDEF) ? PATTERN_PREDEF : '0;
			end else begin
				dev_dq <= array_mem[rd_col[0]];
			end
		end
	end

	// output disable wins over a pending read; data is lost, not delayed
	always_ff @(posedge sys_clk) begin
		if (mem_clear) begin
			dev_dq_oe_n <= 1'b1;
		end else begin
			dev_dq_oe_n <= !(rd_pipe[0] && !output_disabled);
		end
	end

	always_comb begin
		if (!mem.odt) begin
			next_term = DMR_TERM_OFF;
		end else if (wlev) begin
			next_term = (rtt_nom != 3'h0) ? DMR_TERM_NOM : DMR_TERM_OFF;
		end else if (|wr_pipe && (rtt_wr != RTTWR_OFF) && (rtt_wr != RTTWR_RSVD)) begin
			next_term = DMR_TERM_WR;
		end else if (rtt_nom != 3'h0) begin
			next_term = DMR_TERM_NOM;
		end else begin
			next_term = DMR_TERM_OFF;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (mem_clear) begin
			term_state <= DMR_TERM_OFF;
		end else begin
			term_state <= next_term;
		end
	end
endmodule
`default_nettype wire

// File: dmr_if.sv
// dmr_if: command/address bus, memory reset, termination enable and the shared data bus.
// assumes both ends run on the same sys_clk; the dq level is resolved here from the enables.
`timescale 1ns/1ps
`default_nettype none
interface dmr_if import dmr_pkg::*; ;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [BA_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic odt;
	logic rst_n;
	logic [DQ_W-1:0] ctl_dq;
	logic ctl_dq_oe_n;
	logic [DQ_W-1:0] dev_dq;
	logic dev_dq_oe_n;
	logic [DQ_W-1:0] dq;

	// undriven bus reads as zero
	assign dq = !dev_dq_oe_n ? dev_dq : (!ctl_dq_oe_n ? ctl_dq : '0);

	modport dev(input cs_n, ras_n, cas_n, we_n, ba, addr, odt, rst_n, dq,
		output dev_dq, dev_dq_oe_n);
	modport ctl(output cs_n, ras_n, cas_n, we_n, ba, addr, odt, rst_n, ctl_dq, ctl_dq_oe_n,
		input dq, dev_dq_oe_n);
endinterface
`default_nettype wire

// File: dmr_monitor.sv
// dmr_monitor: assertions on the bus between controller end and device end.
// assumes one sys_clk for both ends; fed with the interface signals by the testbench.
`timescale 1ns/1ps
`default_nettype none
module dmr_monitor import dmr_pkg::*; #(
	parameter int CAS_READ = CAS_READ_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic rst_n,
	input wire logic [DQ_W-1:0] dq,
	input wire logic ctl_dq_oe_n,
	input wire logic dev_dq_oe_n
);
	logic [2:0] pins, cwl_c;
	logic cmd, mrs, qoff, pat, loc0;
	logic [1:0] al_c;
	logic [31:0] rd_sr, wr_sr, pat_sr;
	int al, rl, wl;
	assign pins = {ras_n, cas_n, we_n};
	assign cmd = !cs_n;
	assign mrs = cmd && pins == PINS_MRS;
	assign al = al_c == 2'h1 ? CAS_READ - 1 : (al_c == 2'h2 ? CAS_READ - 2 : 0);
	assign rl = al + CAS_READ;
	assign wl = al + 5 + (cwl_c[2] ? 0 : int'(cwl_c[1:0]));
	// mirror clears on the memory reset pin too, as the device does
	always_ff @(posedge sys_clk) begin
		if (reset || !rst_n) begin
			al_c <= '0;
			cwl_c <= '0;
			qoff <= 1'b0;
			pat <= 1'b0;
			loc0 <= 1'b0;
		end else if (mrs && ba == BA_MR1) begin
			al_c <= addr[4:3];
			qoff <= addr[QOFF_BIT];
		end else if (mrs && ba == BA_MR2) begin
			cwl_c <= addr[5:3];
		end else if (mrs && ba == BA_MR3) begin
			pat <= addr[2];
			loc0 <= addr[1:0] == 2'h0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset || !rst_n) begin
			rd_sr <= '0;
			wr_sr <= '0;
			pat_sr <= '0;
		end else begin
			rd_sr <= {rd_sr[30:0], cmd && pins == PINS_RD};
			wr_sr <= {wr_sr[30:0], cmd && pins == PINS_WR};
			pat_sr <= {pat_sr[30:0], cmd && pat && loc0};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	bank_two_low_a:
		assert property (mrs |-> !ba[2]) else $error("mode set with bank bit two high");
	write_rsvd_zero_a:
		assert property (mrs && ba == BA_MR2 |-> (addr & MR2_RSVD_MASK) == '0)
		else $error("write-side reserved bits set");
	pat_rsvd_zero_a:
		assert property (mrs && ba == BA_MR3 |-> addr[13:3] == '0)
		else $error("pattern register reserved bits set");
	read_delay_a:
		assert property (!qoff |-> (!dev_dq_oe_n == rd_sr[rl-1])) else $error("read data off time");
	pattern_data_a:
		assert property (!dev_dq_oe_n && pat_sr[rl-1] |-> dq == PATTERN_PREDEF)
		else $error("pattern read wrong data");
	write_delay_a:
		assert property (ctl_dq_oe_n == !wr_sr[wl-1]) else $error("write data off time");
	outputs_off_a:
		assert property (qoff |-> dev_dq_oe_n) else $error("device drove with outputs off");
	readout_cmds_a:
		assert property (cmd && pat |-> pins == PINS_RD || (mrs && ba == BA_MR3 && !addr[2]))
		else $error("illegal command during readout");
endmodule
`default_nettype wire

// File: dmr_pkg.sv
// dmr_pkg: shared constants, types and decode helpers for the dram mode-register pair.
// assumes one 200 MHz clock shared by the controller end and the device end.
package dmr_pkg;
	localparam int DQ_W = 16;
	localparam int ADDR_W = 14;
	localparam int BA_W = 3;
	localparam int CAS_READ_DEFAULT = 5;
	localparam int CWL_BASE = 5;
	localparam int PIPE_W = 32;
	localparam int MEM_DEPTH_DEFAULT = 16;
	// bank address of each mode register
	localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
	localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
	localparam logic [BA_W-1:0] BA_MR3 = 3'h3;
	// command pins {ras_n, cas_n, we_n} with cs_n low
	localparam logic [2:0] PINS_MRS = 3'h0;
	localparam logic [2:0] PINS_REF = 3'h1;
	localparam logic [2:0] PINS_PRE = 3'h2;
	localparam logic [2:0] PINS_ACT = 3'h3;
	localparam logic [2:0] PINS_WR = 3'h4;
	localparam logic [2:0] PINS_RD = 3'h5;
	localparam logic [2:0] PINS_NOP = 3'h7;
	// first extended mode register fields
	localparam int QOFF_BIT = 12;
	localparam int WLEV_BIT = 7;
	localparam int AL_LSB = 3;
	localparam int NOM_B0 = 2;
	localparam int NOM_B1 = 6;
	localparam int NOM_B2 = 9;
	// write-side mode register fields
	localparam int CWL_LSB = 3;
	localparam int SRT_BIT = 7;
	localparam int RTTWR_LSB = 9;
	localparam logic [ADDR_W-1:0] MR2_RSVD_MASK = 14'h3900;
	// pattern readout mode register fields, then rtt_wr codes and the auto-precharge bit
	localparam int PAT_EN_BIT = 2;
	localparam int PAT_LOC_LSB = 0;
	localparam logic [ADDR_W-1:0] MR3_KEEP_MASK = 14'h0007;
	localparam logic [1:0] LOC_PREDEF = 2'h0;
	localparam logic [DQ_W-1:0] PATTERN_PREDEF = 16'h00ff;
	localparam logic [1:0] RTTWR_OFF = 2'h0;
	localparam logic [1:0] RTTWR_RSVD = 2'h3;
	localparam int AP_BIT = 10;
	// controller register map, byte offsets
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_WDATA = 4'h4;
	localparam logic [3:0] REG_RDATA = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam int CMD_BA_LSB = 4;
	localparam int CMD_ADDR_LSB = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_RVALID = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_PATTERN = 3;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PRECHARGE_NS = 15;
	localparam int PRECHARGE_CYC = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [2:0] {
		DMR_CMD_NOP, DMR_CMD_MRS, DMR_CMD_ACT, DMR_CMD_PRE,
		DMR_CMD_RD, DMR_CMD_WR, DMR_CMD_REF, DMR_CMD_RST
	} dmr_cmd_e;

	typedef enum logic [1:0] {DMR_TERM_OFF, DMR_TERM_NOM, DMR_TERM_WR} dmr_term_e;

	function automatic int cwl_cycles(input logic [2:0] code);
		return code[2] ? CWL_BASE : CWL_BASE + int'(code[1:0]);
	endfunction

	function automatic int al_cycles(input logic [1:0] code, input int cl);
		case (code)
			2'h1: return cl - 1;
			2'h2: return cl - 2;
			default: return 0;
		endcase
	endfunction

	function automatic logic [2:0] cmd_pins(input dmr_cmd_e k);
		case (k)
			DMR_CMD_MRS: return PINS_MRS;
			DMR_CMD_ACT: return PINS_ACT;
			DMR_CMD_PRE: return PINS_PRE;
			DMR_CMD_RD: return PINS_RD;
			DMR_CMD_WR: return PINS_WR;
			DMR_CMD_REF: return PINS_REF;
			default: return PINS_NOP;
		endcase
	endfunction
endpackage

// File: dram_mode_reg_two_three_mpr_tb.sv
// testbench: software drives the controller, the device answers through the interface.
// assumes default CAS_READ; expectations are worked out from the mode register codes.
`timescale 1ns/1ps
`default_nettype none
module dram_mode_reg_two_three_mpr_tb import dmr_pkg::*; ;
	logic sys_clk = 0, reset = 1, avs_read = 0, avs_write = 0, ok;
	logic [3:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd;
	logic avs_waitrequest, pattern_readout, output_disabled, self_refresh_temp_range, mode_reserved;
	logic [5:0] total_write_delay, total_read_delay;
	dmr_term_e term_state;
	int err_total = 0, comparisons = 0, cyc = 0;
	dmr_if mem();
	dmr_device u_dmr_device (.sys_clk(sys_clk), .reset(reset), .mem(mem),
		.total_write_delay(total_write_delay), .total_read_delay(total_read_delay),
		.self_refresh_temp_range(self_refresh_temp_range), .pattern_readout(pattern_readout),
		.output_disabled(output_disabled), .term_state(term_state), .mode_reserved(mode_reserved));
	dmr_controller u_dmr_controller (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem(mem));
	dmr_monitor u_dmr_monitor (.sys_clk(sys_clk), .reset(reset), .cs_n(mem.cs_n),
		.ras_n(mem.ras_n), .cas_n(mem.cas_n), .we_n(mem.we_n), .ba(mem.ba), .addr(mem.addr),
		.rst_n(mem.rst_n), .dq(mem.dq), .ctl_dq_oe_n(mem.ctl_dq_oe_n),
		.dev_dq_oe_n(mem.dev_dq_oe_n));
	always #2.5 sys_clk = ~sys_clk;
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// the whole run needs about 340 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one extra edge after release keeps two requests out of one time step
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic cmd(input logic [2:0] k, input logic [2:0] b, input logic [13:0] a);
		bus(1'b1, REG_CMD, {2'h0, a, 9'h0, b, 1'h0, k});
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic fetch(input logic [13:0] col);
		cmd(3'h4, 3'h0, col);
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			bus(1'b0, REG_STATUS, '0);
			ok = rd[ST_RVALID] === 1'b1;
		end
		bus(1'b0, REG_RDATA, '0);
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic t_defaults();
		chk(total_write_delay, 32'h5, "wl at reset");
		chk(total_read_delay, 32'h5, "rl at reset");
		chk(term_state, DMR_TERM_OFF, "term at reset");
		bus(1'b0, 4'h2, '0);
		chk(rd, 32'h0, "unmapped read");
	endtask
	task automatic t_write();
		for (int c = 0; c < 4; c++) begin
			cmd(3'h1, BA_MR2, 14'(c << 3) | MR2_RSVD_MASK);
			chk(total_write_delay, 32'(5 + c), "cwl code");
		end
		cmd(3'h1, BA_MR2, 14'h0280);
		chk(self_refresh_temp_range, 32'h1, "srt");
		cmd(3'h1, BA_MR1, 14'h0010);
		chk(total_read_delay, 32'h8, "rl with al");
		chk(total_write_delay, 32'h8, "wl with al");
		cmd(3'h3, 3'h0, 14'h0400);
		cmd(3'h2, 3'h0, 14'h0001);
		bus(1'b1, REG_WDATA, 32'h0000c35a);
		cmd(3'h5, 3'h0, 14'h0003);
		chk(term_state, DMR_TERM_WR, "rtt_wr without nominal");
		fetch(14'h0003);
		chk(rd, 32'h0000c35a, "read back");
		cmd(3'h1, BA_MR2, 14'h0620);
		chk(total_write_delay, 32'h8, "reserved cwl");
		chk(mode_reserved, 32'h1, "reserved codes");
	endtask
	task automatic t_level();
		cmd(3'h1, BA_MR1, 14'h0084);
		cmd(3'h1, BA_MR2, 14'h0200);
		cmd(3'h2, 3'h0, 14'h0001);
		cmd(3'h5, 3'h0, 14'h0001);
		chk(term_state, DMR_TERM_NOM, "leveling term");
	endtask
	task automatic t_pattern();
		cmd(3'h2, 3'h0, 14'h0001);
		bus(1'b1, REG_WDATA, 32'h00001234);
		cmd(3'h5, 3'h0, 14'h0002);
		cmd(3'h1, BA_MR3, 14'h0001);
		chk(pattern_readout, 32'h0, "location alone");
		chk(mode_reserved, 32'h0, "location ignored");
		fetch(14'h0002);
		chk(rd, 32'h00001234, "array read");
		cmd(3'h1, BA_MR3, 14'h0004);
		bus(1'b0, REG_STATUS, '0);
		chk(rd[ST_REFUSED], 32'h1, "enable with open bank");
		bus(1'b1, REG_STATUS, 32'h4);
		cmd(3'h3, 3'h0, 14'h0400);
		cmd(3'h1, BA_MR3, 14'h0004);
		chk(pattern_readout, 32'h1, "readout on");
		fetch(14'h0002);
		chk(rd, 32'(PATTERN_PREDEF), "pattern read");
		bus(1'b0, REG_STATUS, '0);
		chk(rd[ST_PATTERN], 32'h1, "pattern shadow");
		cmd(3'h2, 3'h0, 14'h0001);
		bus(1'b0, REG_STATUS, '0);
		chk(rd[ST_REFUSED], 32'h1, "act in readout");
		bus(1'b1, REG_STATUS, 32'h4);
		bus(1'b0, REG_STATUS, '0);
		chk(rd[ST_REFUSED], 32'h0, "refused cleared");
		cmd(3'h6, 3'h0, 14'h0000);
		bus(1'b0, REG_STATUS, '0);
		chk(rd[ST_REFUSED], 32'h1, "refresh in readout");
		cmd(3'h1, BA_MR3, 14'h0000);
		chk(pattern_readout, 32'h0, "readout off");
		cmd(3'h1, BA_MR3, 14'h0005);
		chk(mode_reserved, 32'h1, "reserved location");
		cmd(3'h7, 3'h0, 14'h0000);
		chk(pattern_readout, 32'h0, "memory reset");
	endtask
	task automatic t_qoff();
		cmd(3'h1, BA_MR1, 14'h1000);
		chk(output_disabled, 32'h1, "outputs off");
		cmd(3'h2, 3'h0, 14'h0001);
		fetch(14'h0001);
		chk(ok, 32'h0, "read while off");
	endtask
	initial begin
		do_reset();
		t_defaults();
		t_write();
		do_reset();
		t_level();
		do_reset();
		t_pattern();
		do_reset();
		t_qoff();
		conclude();
	end
endmodule
`default_nettype wire
